// ---- shared/line_intl_cfg.svh ----
`ifndef LINE_INTL_CFG_SVH
`define LINE_INTL_CFG_SVH

// register addresses on the control port
`define ADDR_LINE_CTL3      8'h12
`define ADDR_OVL_STATUS     8'h13

// line control register fields
`define CTL3_DIAL_BIT       6
`define CTL3_FORCE_BIT      5
`define CTL3_VOL_HI         4
`define CTL3_VOL_LO         3
`define CTL3_FULL_WAVE_BIT  1
`define CTL3_SQUELCH_BIT    0
`define CTL3_WRITE_MASK     8'h7b
`define CTL3_RESET_VAL      8'h00

// overload status register fields
`define STAT_OVL_BIT        2
`define STAT_BIT7_VAL       1'b0

// termination select code for standard voltage mode
`define TERM_STD_VOLT       2'b10

// line voltage steps, signed units of 0.125 V
`define VOL_CODE_NORMAL     2'b00
`define VOL_CODE_DOWN_1     2'b01
`define VOL_CODE_UP_2       2'b10
`define VOL_CODE_UP_1       2'b11
`define VOL_STEP_NONE       3'h0
`define VOL_STEP_DOWN_1     3'h7
`define VOL_STEP_UP_2       3'h2
`define VOL_STEP_UP_1       3'h1

`endif

// ---- shared/line_intl_pkg.sv ----
package line_intl_pkg;

    typedef struct packed {
        logic [7:0] line_ctl;
        logic       ovl_live;
        logic       ovl_sticky;
        logic [7:0] rdata;
        logic       rvalid;
        logic       ring_ind_n;
        logic       force_lv;
        logic [2:0] volt_step;
    } ctrl_state_t;

endpackage : line_intl_pkg

// ---- src/pin_sync3.sv ----
`timescale 1ns/10ps
module pin_sync3 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_state_t;

    sync_state_t st_reg;
    sync_state_t st_next;

    // a change counts once second and third stages agree
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < W; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.q[i] = st_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.q;
endmodule : pin_sync3

// ---- src/line_intl_control_regs.sv ----
`timescale 1ns/10ps
`include "line_intl_cfg.svh"
module line_intl_control_regs (
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic       REG_WR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    output logic            REG_RVALID,
    input  wire logic [1:0] TERMINATION_SELECT,
    input  wire logic       BILLING_TONE_ENABLE,
    input  wire logic       OVERLOAD_STICKY_CLR,
    input  wire logic       RX_OVERLOAD,
    input  wire logic       RING_SENSE_POS,
    input  wire logic       RING_SENSE_NEG,
    output logic            DIAL_HEADROOM,
    output logic            FORCE_LOW_VOLT_TERM,
    output logic      [2:0] LINE_VOLT_STEP,
    output logic            RING_FULL_WAVE_SELECT,
    output logic            RING_NETWORK_SQUELCH,
    output logic            RING_INDICATOR_OUT_N,
    output logic            OVERLOAD_LIVE_FLAG,
    output logic            OVERLOAD_STICKY_FLAG
);
    line_intl_pkg::ctrl_state_t st_reg;
    line_intl_pkg::ctrl_state_t st_next;
    logic [2:0]                 pins_s;
    logic                       rx_ovl_s;
    logic                       ring_pos_s;
    logic                       ring_neg_s;
    logic                       wr_ctl;
    logic [7:0]                 status_val;

    pin_sync3 #(
        .W (3)
    ) u_pin_sync (
        .clk  (CLK),
        .rst  (SYS_RST),
        .din  ({RX_OVERLOAD, RING_SENSE_NEG, RING_SENSE_POS}),
        .dout (pins_s)
    );

    assign rx_ovl_s   = pins_s[2];
    assign ring_neg_s = pins_s[1];
    assign ring_pos_s = pins_s[0];
    assign wr_ctl     = REG_WR && (REG_ADDR == `ADDR_LINE_CTL3);

    always_comb begin
        status_val                 = 8'h00;
        status_val[7]              = `STAT_BIT7_VAL;
        status_val[`STAT_OVL_BIT]  = st_reg.ovl_live;
    end

    always_comb begin
        st_next        = st_reg;
        st_next.rvalid = 1'b0;
        if (wr_ctl) begin
            st_next.line_ctl = REG_WDATA & `CTL3_WRITE_MASK;
        end
        if (REG_RD) begin
            st_next.rvalid = 1'b1;
            case (REG_ADDR)
                `ADDR_LINE_CTL3:  st_next.rdata = st_reg.line_ctl;
                `ADDR_OVL_STATUS: st_next.rdata = status_val;
                default:          st_next.rdata = 8'h00;
            endcase
        end
        // live flag tracks the pin, gated by billing tone enable
        st_next.ovl_live = BILLING_TONE_ENABLE && rx_ovl_s;
        // set wins over a clear in the same cycle
        if (BILLING_TONE_ENABLE && rx_ovl_s) begin
            st_next.ovl_sticky = 1'b1;
        end else if (OVERLOAD_STICKY_CLR) begin
            st_next.ovl_sticky = 1'b0;
        end
        st_next.force_lv = st_reg.line_ctl[`CTL3_FORCE_BIT]
                           && (TERMINATION_SELECT == `TERM_STD_VOLT);
        case (st_reg.line_ctl[`CTL3_VOL_HI:`CTL3_VOL_LO])
            `VOL_CODE_NORMAL: st_next.volt_step = `VOL_STEP_NONE;
            `VOL_CODE_DOWN_1: st_next.volt_step = `VOL_STEP_DOWN_1;
            `VOL_CODE_UP_2:   st_next.volt_step = `VOL_STEP_UP_2;
            `VOL_CODE_UP_1:   st_next.volt_step = `VOL_STEP_UP_1;
            default:          st_next.volt_step = `VOL_STEP_NONE;
        endcase
        // half wave sees the positive lobe only
        st_next.ring_ind_n = !(ring_pos_s
                               || (st_reg.line_ctl[`CTL3_FULL_WAVE_BIT] && ring_neg_s));
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            st_reg            <= '0;
            st_reg.line_ctl   <= `CTL3_RESET_VAL;
            st_reg.ring_ind_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign REG_RDATA             = st_reg.rdata;
    assign REG_RVALID            = st_reg.rvalid;
    assign DIAL_HEADROOM         = st_reg.line_ctl[`CTL3_DIAL_BIT];
    assign FORCE_LOW_VOLT_TERM   = st_reg.force_lv;
    assign LINE_VOLT_STEP        = st_reg.volt_step;
    assign RING_FULL_WAVE_SELECT = st_reg.line_ctl[`CTL3_FULL_WAVE_BIT];
    assign RING_NETWORK_SQUELCH  = st_reg.line_ctl[`CTL3_SQUELCH_BIT];
    assign RING_INDICATOR_OUT_N  = st_reg.ring_ind_n;
    assign OVERLOAD_LIVE_FLAG    = st_reg.ovl_live;
    assign OVERLOAD_STICKY_FLAG  = st_reg.ovl_sticky;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    sequence ctl_write_s;
        REG_WR && (REG_ADDR == `ADDR_LINE_CTL3);
    endsequence

    sequence ctl_readback_s;
        REG_RD && (REG_ADDR == `ADDR_LINE_CTL3);
    endsequence

    sequence sticky_set_s;
        BILLING_TONE_ENABLE && rx_ovl_s;
    endsequence

    sequence force_write_s;
        ctl_write_s ##0 REG_WDATA[`CTL3_FORCE_BIT];
    endsequence

    sequence write_then_read_s;
        ctl_write_s ##1 !REG_WR ##1 ctl_readback_s ##0 !REG_WR;
    endsequence

    sequence ovl_gone_s;
        (!rx_ovl_s && !OVERLOAD_STICKY_CLR) ##1 (!rx_ovl_s && !OVERLOAD_STICKY_CLR);
    endsequence

    headroom_write_a: assert property (ctl_write_s |=> DIAL_HEADROOM == $past(REG_WDATA[`CTL3_DIAL_BIT])
        ##1 ($past(REG_WR && REG_ADDR == `ADDR_LINE_CTL3) || $stable(DIAL_HEADROOM)))
        else $error("headroom bit not taken from write");

    dial_clear_a: assert property (ctl_write_s ##0 !REG_WDATA[`CTL3_DIAL_BIT] |=> !DIAL_HEADROOM)
        else $error("headroom bit not cleared");

    force_term_a: assert property (##1 FORCE_LOW_VOLT_TERM ==
        $past(st_reg.line_ctl[5] && TERMINATION_SELECT == 2'b10))
        else $error("forced termination wrong");

    force_on_a: assert property (force_write_s ##1 (TERMINATION_SELECT == 2'b10) |=> FORCE_LOW_VOLT_TERM)
        else $error("forced termination not applied");

    force_off_a: assert property (TERMINATION_SELECT != 2'b10 |=> !FORCE_LOW_VOLT_TERM)
        else $error("forced termination outside standard mode");

    volt_map_a: assert property (st_reg.line_ctl[4:3] == 2'b01 |=> LINE_VOLT_STEP == 3'h7)
        else $error("line voltage step wrong");

    volt_normal_a: assert property (st_reg.line_ctl[4:3] == 2'b00 |=> LINE_VOLT_STEP == 3'h0)
        else $error("line voltage step not zero");

    volt_up2_a: assert property (st_reg.line_ctl[4:3] == 2'b10 |=> LINE_VOLT_STEP == 3'h2)
        else $error("line voltage step not two up");

    volt_up1_a: assert property (st_reg.line_ctl[4:3] == 2'b11 |=> LINE_VOLT_STEP == 3'h1)
        else $error("line voltage step not one up");

    ring_rect_a: assert property (ring_neg_s && !ring_pos_s |=>
        RING_INDICATOR_OUT_N == !$past(RING_FULL_WAVE_SELECT))
        else $error("ring rectification wrong");

    ring_pos_a: assert property (ring_pos_s |=> !RING_INDICATOR_OUT_N)
        else $error("positive ring lobe not indicated");

    ring_idle_a: assert property (!ring_pos_s && !ring_neg_s |=> RING_INDICATOR_OUT_N)
        else $error("ring indicated without ring");

    full_wave_write_a: assert property (ctl_write_s |=>
        RING_FULL_WAVE_SELECT == $past(REG_WDATA[`CTL3_FULL_WAVE_BIT]))
        else $error("rectifier select not taken from write");

    squelch_write_a: assert property (ctl_write_s ##0 REG_WDATA[0] |=> RING_NETWORK_SQUELCH)
        else $error("squelch not enabled");

    squelch_clear_a: assert property (ctl_write_s ##0 !REG_WDATA[`CTL3_SQUELCH_BIT] |=> !RING_NETWORK_SQUELCH)
        else $error("squelch not released");

    live_gate_a: assert property (!BILLING_TONE_ENABLE || !rx_ovl_s |=> !OVERLOAD_LIVE_FLAG)
        else $error("live overload flag not cleared");

    overload_gone_a: assert property (sticky_set_s ##1 ovl_gone_s |=> !OVERLOAD_LIVE_FLAG
        && OVERLOAD_STICKY_FLAG)
        else $error("overload flags wrong after overload ends");

    status_write_a: assert property (REG_WR && REG_ADDR == `ADDR_OVL_STATUS |=> $stable(st_reg.line_ctl))
        else $error("status write changed control");

    live_set_a: assert property (sticky_set_s |=> OVERLOAD_LIVE_FLAG && OVERLOAD_STICKY_FLAG)
        else $error("overload flags not set");

    sticky_gate_a: assert property (!BILLING_TONE_ENABLE && !OVERLOAD_STICKY_FLAG |=> !OVERLOAD_STICKY_FLAG)
        else $error("sticky flag set while billing tone off");

    sticky_hold_a: assert property (OVERLOAD_STICKY_FLAG && !OVERLOAD_STICKY_CLR |=> OVERLOAD_STICKY_FLAG)
        else $error("sticky flag dropped without clear");

    sticky_wins_a: assert property (sticky_set_s ##0 OVERLOAD_STICKY_CLR |=> OVERLOAD_STICKY_FLAG)
        else $error("sticky clear beat a new overload");

    sticky_clear_a: assert property (OVERLOAD_STICKY_CLR && !(BILLING_TONE_ENABLE && rx_ovl_s)
        |=> !OVERLOAD_STICKY_FLAG)
        else $error("sticky flag not cleared");

    status_read_a: assert property (REG_RD && REG_ADDR == `ADDR_OVL_STATUS |=> REG_RVALID
        && REG_RDATA[6:3] == 4'h0 && REG_RDATA[1:0] == 2'h0 && REG_RDATA[2] == $past(OVERLOAD_LIVE_FLAG))
        else $error("status read value wrong");

    ctl_reserved_a: assert property (ctl_readback_s |=> REG_RVALID && REG_RDATA[7] == 1'b0
        && REG_RDATA[2] == 1'b0)
        else $error("control reserved bits not zero");

    write_readback_a: assert property (write_then_read_s |=> REG_RVALID
        && REG_RDATA == ($past(REG_WDATA, 3) & 8'h7b))
        else $error("control readback differs from write");
endmodule : line_intl_control_regs

// ---- test/line_host_model.sv ----
`timescale 1ns/10ps
module line_host_model (
    input  wire logic       CLK,
    output logic      [7:0] REG_ADDR,
    output logic            REG_WR,
    output logic            REG_RD,
    output logic      [7:0] REG_WDATA,
    input  wire logic [7:0] REG_RDATA,
    input  wire logic       REG_RVALID
);
    initial begin
        {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = '0;
    end
    // byte write; one-cycle REG_WR pulse, then data inverted
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK) #1;
        {REG_ADDR, REG_WDATA, REG_WR} = {a, d, 1'b1};
        @(posedge CLK) #1;
        {REG_WDATA, REG_WR} = {~d, 1'b0};
    endtask : wr
    task rd(input logic [7:0] a, output logic [8:0] q);
        @(posedge CLK) #1;
        {REG_ADDR, REG_RD} = {a, 1'b1};
        @(posedge CLK) #1;
        REG_RD = 1'b0;
        q = {REG_RVALID, REG_RDATA};
    endtask : rd
endmodule : line_host_model

// ---- test/line_intl_control_regs_bench.sv ----
`timescale 1ns/10ps
module line_intl_control_regs_bench;
    logic       clk, rst, wr, rd, rvalid, billing_tone_enable, clr, overload_live_flag, pos, neg;
    logic [7:0] addr, wdata, rdata;
    logic [1:0] term;
    logic [2:0] step;
    logic       dial, force_lv, full, sq, ring_n, live, sticky;
    logic [8:0] q;
    logic [2:0] vstep [4] = '{3'h0, 3'h7, 3'h2, 3'h1};
    int         num_errors, tests_run, cycles;
    line_intl_control_regs uut (.CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
        .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid), .TERMINATION_SELECT(term),
        .BILLING_TONE_ENABLE(billing_tone_enable), .OVERLOAD_STICKY_CLR(clr), .RX_OVERLOAD(overload_live_flag), .RING_SENSE_POS(pos),
        .RING_SENSE_NEG(neg), .DIAL_HEADROOM(dial), .FORCE_LOW_VOLT_TERM(force_lv), .LINE_VOLT_STEP(step),
        .RING_FULL_WAVE_SELECT(full), .RING_NETWORK_SQUELCH(sq), .RING_INDICATOR_OUT_N(ring_n),
        .OVERLOAD_LIVE_FLAG(live), .OVERLOAD_STICKY_FLAG(sticky));
    line_host_model host (.CLK(clk), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .REG_RVALID(rvalid));
    task chk(input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task close_out;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            close_out;
        end
    end
    initial begin
        {billing_tone_enable, clr, overload_live_flag, pos, neg} = '0;
        term = 2'b00;
        rst = 1'b1;
        wt(10);
        rst = 1'b0;
        host.rd(8'h12, q);
        chk(q, 9'h100);
        host.rd(8'h13, q);
        chk(q, 9'h100);
        chk(9'(ring_n), 9'h001);
        $display("reset test done");
        host.wr(8'h12, 8'hff);
        host.rd(8'h12, q);
        chk(q, 9'h17b);
        chk(9'({dial, full, sq}), 9'h007);
        chk(9'(force_lv), 9'h000);
        term = 2'b10;
        wt(2);
        chk(9'(force_lv), 9'h001);
        host.wr(8'h12, 8'h20);
        wt(1);
        chk(9'(force_lv), 9'h001);
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h12, 8'(i << 3));
            wt(1);
            chk(9'(step), 9'(vstep[i]));
        end
        chk(9'({dial, force_lv, full, sq}), 9'h000);
        host.wr(8'h13, 8'hff);
        host.rd(8'h13, q);
        chk(q, 9'h100);
        host.rd(8'h40, q);
        chk(q, 9'h100);
        $display("register test done");
        overload_live_flag = 1'b1;
        wt(8);
        chk(9'({live, sticky}), 9'h000);
        billing_tone_enable = 1'b1;
        wt(3);
        chk(9'({live, sticky}), 9'h003);
        host.rd(8'h13, q);
        chk(q, 9'h104);
        clr = 1'b1;
        wt(1);
        clr = 1'b0;
        chk(9'(sticky), 9'h001);
        overload_live_flag = 1'b0;
        wt(8);
        chk(9'({live, sticky}), 9'h001);
        clr = 1'b1;
        wt(1);
        clr = 1'b0;
        wt(1);
        chk(9'(sticky), 9'h000);
        $display("overload test done");
        neg = 1'b1;
        wt(8);
        chk(9'(ring_n), 9'h001);
        host.wr(8'h12, 8'h02);
        wt(2);
        chk(9'(ring_n), 9'h000);
        neg = 1'b0;
        pos = 1'b1;
        wt(8);
        chk(9'(ring_n), 9'h000);
        pos = 1'b0;
        wt(8);
        chk(9'(ring_n), 9'h001);
        $display("ring test done");
        host.wr(8'h12, 8'h01);
        wt(1);
        chk(9'(sq), 9'h001);
        wt(25000);
        host.wr(8'h12, 8'h00);
        wt(1);
        chk(9'(sq), 9'h000);
        $display("squelch test done");
        close_out;
    end
endmodule : line_intl_control_regs_bench
